// ==== design/xfr_consts.vh ====
// Shared constants for the octal serial flash command sequencer.
`ifndef XFR_CONSTS_VH
`define XFR_CONSTS_VH

// ****************************************************************
// Command codes
// ****************************************************************
`define XFR_OP_READ 8'h03
`define XFR_OP_READ4 8'h13
`define XFR_OP_FAST 8'h0B
`define XFR_OP_FAST4 8'h0C
`define XFR_OP_OOUT 8'h8B
`define XFR_OP_OOUT4 8'h7C
`define XFR_OP_OIO 8'hCB
`define XFR_OP_OIO4 8'hCC
`define XFR_OP_DDR_OOUT 8'h9D
`define XFR_OP_DDR_OIO 8'hFD
`define XFR_OP_WREN 8'h06
`define XFR_OP_WRDI 8'h04
`define XFR_OP_CLR_FLAG 8'h50
`define XFR_OP_RD_STATUS 8'h05
`define XFR_OP_RD_FLAG 8'h70
`define XFR_OP_RD_NVCFG 8'hB5
`define XFR_OP_RD_VCFG 8'h85
`define XFR_OP_WR_STATUS 8'h01
`define XFR_OP_WR_NVCFG 8'hB1

// ****************************************************************
// Command kinds produced by the decoder
// ****************************************************************
`define XFR_K_NONE 3'h0
`define XFR_K_MEM 3'h1
`define XFR_K_REG 3'h2
`define XFR_K_CFG 3'h3
`define XFR_K_WEN 3'h4
`define XFR_K_WDI 3'h5
`define XFR_K_CLF 3'h6
`define XFR_K_WRR 3'h7

// ****************************************************************
// Phase sizes and timing
// ****************************************************************
`define XFR_BYTE_BITS 6'h08
`define XFR_ADDR3_BITS 6'h18
`define XFR_ADDR4_BITS 6'h20
`define XFR_CMD_OCT_BITS 6'h10
`define XFR_LANE_ONE 1
`define XFR_LANE_ONE_OE 8'h02
`define XFR_ALL_OE 8'hFF
`define XFR_CLK_MHZ 50
`define XFR_NS_PER_US 1000

`endif

// ==== design/xfr_core.v ====
// Device-side command sequencer of an expanded SPI octal flash.
`timescale 1ns/1ps
`include "xfr_consts.vh"

module xfr_core #(
    parameter STATUS_WRITE_TIME_NS = 5000000,
    parameter NVCONFIG_WRITE_TIME_NS = 5000000,
    parameter [7:0] NVCFG_RSVD_MASK = 8'h00,
    parameter [7:0] VCFG_RSVD_MASK = 8'h00
) (
    // Clock and reset.
    input wire clk_sys,
    input wire rst_n,
    // Serial pins to and from the host.
    input wire sclk,
    input wire sel_n,
    input wire [7:0] lanes_in,
    output reg [7:0] lanes_out,
    output reg [7:0] lanes_oe,
    // Configuration.
    input wire octal_ddr_mode,
    input wire addr4_mode,
    input wire [4:0] dummy_cycles,
    input wire prot_err,
    // Register contents supplied by the surrounding device.
    input wire [5:0] status_upper,
    input wire [7:0] flag_status,
    input wire [7:0] nvcfg_value,
    input wire [7:0] vcfg_value,
    // Memory array read port.
    output reg [31:0] mem_addr,
    output reg mem_rd_stb,
    input wire [7:0] mem_rdata,
    // Device state and write commits.
    output reg write_enable_latch,
    output wire write_in_progress,
    output reg reg_wr_stb,
    output reg reg_wr_nvcfg,
    output reg [15:0] reg_wr_data,
    output reg clr_flag_stb
);

    // ****************************************************************
    // Constants
    // ****************************************************************

    // Least times round up to whole cycles.
    localparam [31:0] SR_CYC = (STATUS_WRITE_TIME_NS * `XFR_CLK_MHZ + `XFR_NS_PER_US - 1) / `XFR_NS_PER_US;
    localparam [31:0] NV_CYC = (NVCONFIG_WRITE_TIME_NS * `XFR_CLK_MHZ + `XFR_NS_PER_US - 1) / `XFR_NS_PER_US;
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_CMD = 3'h1;
    localparam [2:0] ST_ADDR = 3'h2;
    localparam [2:0] ST_DUMMY = 3'h3;
    localparam [2:0] ST_DATA = 3'h4;
    localparam [2:0] ST_HOLD = 3'h5;
    localparam [2:0] ST_WDATA = 3'h6;
    localparam [2:0] ST_SKIP = 3'h7;

    // ****************************************************************
    // Decoder
    // ****************************************************************

    // Returns {kind, addr_oct, addr_ddr, data_oct, data_ddr, addr4, dummy}.
    function [8:0] fmt_of;
        input [7:0] op;
        input oct;
        input a4m;
        begin
            fmt_of = {`XFR_K_NONE, 6'h00};
            if (oct) begin
                case (op)
                    `XFR_OP_FAST, `XFR_OP_FAST4, `XFR_OP_OOUT, `XFR_OP_OOUT4, `XFR_OP_OIO, `XFR_OP_OIO4,
                    `XFR_OP_DDR_OOUT, `XFR_OP_DDR_OIO: fmt_of = {`XFR_K_MEM, 6'h3F};
                    `XFR_OP_RD_STATUS, `XFR_OP_RD_FLAG: fmt_of = {`XFR_K_REG, 6'h3E};
                    `XFR_OP_RD_NVCFG, `XFR_OP_RD_VCFG: fmt_of = {`XFR_K_CFG, 6'h3E};
                    `XFR_OP_WREN: fmt_of = {`XFR_K_WEN, 6'h3E};
                    `XFR_OP_WRDI: fmt_of = {`XFR_K_WDI, 6'h3E};
                    `XFR_OP_CLR_FLAG: fmt_of = {`XFR_K_CLF, 6'h3E};
                    `XFR_OP_WR_STATUS, `XFR_OP_WR_NVCFG: fmt_of = {`XFR_K_WRR, 6'h3E};
                    default: fmt_of = {`XFR_K_NONE, 6'h00};
                endcase
            end else begin
                case (op)
                    `XFR_OP_READ: fmt_of = {`XFR_K_MEM, 4'h0, a4m, 1'b0};
                    `XFR_OP_READ4: fmt_of = {`XFR_K_MEM, 6'h02};
                    `XFR_OP_FAST: fmt_of = {`XFR_K_MEM, 4'h0, a4m, 1'b1};
                    `XFR_OP_FAST4: fmt_of = {`XFR_K_MEM, 6'h03};
                    `XFR_OP_OOUT: fmt_of = {`XFR_K_MEM, 4'h2, a4m, 1'b1};
                    `XFR_OP_OOUT4: fmt_of = {`XFR_K_MEM, 6'h0B};
                    `XFR_OP_OIO: fmt_of = {`XFR_K_MEM, 4'hA, a4m, 1'b1};
                    `XFR_OP_OIO4: fmt_of = {`XFR_K_MEM, 6'h2B};
                    `XFR_OP_DDR_OOUT: fmt_of = {`XFR_K_MEM, 4'h7, a4m, 1'b1};
                    `XFR_OP_DDR_OIO: fmt_of = {`XFR_K_MEM, 6'h3F};
                    `XFR_OP_RD_STATUS, `XFR_OP_RD_FLAG: fmt_of = {`XFR_K_REG, 6'h00};
                    `XFR_OP_RD_NVCFG, `XFR_OP_RD_VCFG: fmt_of = {`XFR_K_CFG, 4'h0, a4m, 1'b0};
                    `XFR_OP_WREN: fmt_of = {`XFR_K_WEN, 6'h00};
                    `XFR_OP_WRDI: fmt_of = {`XFR_K_WDI, 6'h00};
                    `XFR_OP_CLR_FLAG: fmt_of = {`XFR_K_CLF, 6'h00};
                    `XFR_OP_WR_STATUS, `XFR_OP_WR_NVCFG: fmt_of = {`XFR_K_WRR, 6'h00};
                    default: fmt_of = {`XFR_K_NONE, 6'h00};
                endcase
            end
        end
    endfunction

    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************

    // Synchronised clock, select and lanes.
    wire [9:0] pins_s;
    // Previous synchronised serial clock.
    reg sclk_d_ff;
    wire sclk_s = pins_s[9];
    // Select travels inverted so that the cleared stages read as deselected after reset.
    wire sel_n_s = ~pins_s[8];
    wire [7:0] lanes_s = pins_s[7:0];
    wire sclk_rise = sclk_s & ~sclk_d_ff;
    wire sclk_fall = ~sclk_s & sclk_d_ff;

    xfr_sync #(.WIDTH(10)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({sclk, ~sel_n, lanes_in}),
        .sync_out(pins_s)
    );

    // ****************************************************************
    // Sequencer state
    // ****************************************************************

    reg [2:0] state_ff;
    // Latched command format fields.
    reg [2:0] kind_ff;
    reg a_oct_ff, a_ddr_ff, d_oct_ff, d_ddr_ff, a4_ff, dum_ff;
    reg [7:0] op_ff;
    // Bits received in the current phase.
    reg [5:0] bit_cnt_ff;
    reg [15:0] cmd_sr_ff;
    reg [15:0] wr_sr_ff;
    // Set once a whole write data byte has arrived.
    reg wr_any_ff;
    reg [4:0] dum_cnt_ff;
    reg [7:0] out_sr_ff;
    // Bits of the current output byte still to drive.
    reg [2:0] out_cnt_ff;
    // Timer control.
    reg timer_start_ff;
    wire timer_done;

    // Phase widths and data-rate flags for the current state.
    wire in_oct = (state_ff == ST_ADDR) ? a_oct_ff : (state_ff == ST_CMD) ? octal_ddr_mode : d_oct_ff;
    wire in_ddr = (state_ff == ST_ADDR) ? a_ddr_ff : (state_ff == ST_CMD) ? octal_ddr_mode : d_ddr_ff;
    wire in_ev = sclk_rise | (sclk_fall & in_ddr);
    wire out_ev = sclk_fall | (sclk_rise & d_ddr_ff);
    wire [5:0] in_step = in_oct ? `XFR_BYTE_BITS : 6'h01;
    wire [5:0] bit_nxt = bit_cnt_ff + in_step;
    wire [15:0] cmd_shift = octal_ddr_mode ? {cmd_sr_ff[7:0], lanes_s} : {cmd_sr_ff[14:0], lanes_s[0]};
    wire [7:0] cmd_now = octal_ddr_mode ? cmd_shift[15:8] : cmd_shift[7:0];
    wire [5:0] cmd_bits = octal_ddr_mode ? `XFR_CMD_OCT_BITS : `XFR_BYTE_BITS;
    wire [8:0] fmt_now = fmt_of(cmd_now, octal_ddr_mode, addr4_mode);
    // While a write runs only the two status reads are accepted.
    wire [2:0] kind_now = (write_in_progress && fmt_now[8:6] != `XFR_K_REG) ? `XFR_K_NONE : fmt_now[8:6];
    wire [5:0] addr_bits = a4_ff ? `XFR_ADDR4_BITS : `XFR_ADDR3_BITS;
    wire [15:0] wr_shift = d_oct_ff ? {wr_sr_ff[7:0], lanes_s} : {wr_sr_ff[14:0], lanes_s[0]};
    wire [31:0] addr_shift = a_oct_ff ? {mem_addr[23:0], lanes_s} : {mem_addr[30:0], lanes_s[0]};

    // Byte presented by register reads; reserved bits of the two configuration registers forced high.
    reg [7:0] reg_byte;
    always @* begin
        if (op_ff == `XFR_OP_RD_STATUS) begin
            reg_byte = {status_upper, write_enable_latch, write_in_progress};
        end else if (op_ff == `XFR_OP_RD_FLAG) begin
            reg_byte = flag_status;
        end else if (op_ff == `XFR_OP_RD_NVCFG) begin
            reg_byte = nvcfg_value | NVCFG_RSVD_MASK;
        end else begin
            reg_byte = vcfg_value | VCFG_RSVD_MASK;
        end
    end
    wire [7:0] out_byte = (kind_ff == `XFR_K_MEM) ? mem_rdata : reg_byte;

    // ****************************************************************
    // Main sequencer
    // ****************************************************************

    // Every phase after ST_IDLE advances only on detected serial clock edges; select high always wins.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sclk_d_ff <= 1'b0;
            state_ff <= ST_IDLE;
            kind_ff <= `XFR_K_NONE;
            {a_oct_ff, a_ddr_ff, d_oct_ff, d_ddr_ff, a4_ff, dum_ff} <= 6'h00;
            op_ff <= 8'h00;
            bit_cnt_ff <= 6'h00;
            cmd_sr_ff <= 16'h0000;
            wr_sr_ff <= 16'h0000;
            wr_any_ff <= 1'b0;
            dum_cnt_ff <= 5'h00;
            out_sr_ff <= 8'h00;
            out_cnt_ff <= 3'h0;
            lanes_out <= 8'h00;
            lanes_oe <= 8'h00;
            mem_addr <= 32'h0000_0000;
            mem_rd_stb <= 1'b0;
            write_enable_latch <= 1'b0;
            reg_wr_stb <= 1'b0;
            reg_wr_nvcfg <= 1'b0;
            reg_wr_data <= 16'h0000;
            clr_flag_stb <= 1'b0;
            timer_start_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
            mem_rd_stb <= 1'b0;
            reg_wr_stb <= 1'b0;
            clr_flag_stb <= 1'b0;
            timer_start_ff <= 1'b0;
            // Completion of a self-timed write drops the latch, success or not.
            if (timer_done) begin
                write_enable_latch <= 1'b0;
            end
            if (sel_n_s) begin
                // Select high ends output at once and commits held commands, except a disable while prot_err is set.
                lanes_oe <= 8'h00;
                state_ff <= ST_IDLE;
                if (state_ff == ST_HOLD) begin
                    if (kind_ff == `XFR_K_WEN) begin
                        write_enable_latch <= 1'b1;
                    end else if (kind_ff == `XFR_K_WDI && !prot_err) begin
                        write_enable_latch <= 1'b0;
                    end else if (kind_ff == `XFR_K_CLF) begin
                        write_enable_latch <= 1'b0;
                        clr_flag_stb <= 1'b1;
                    end
                end else if (state_ff == ST_WDATA && wr_any_ff && bit_cnt_ff[2:0] == 3'h0 && write_enable_latch) begin
                    // Only a clean byte boundary with the latch set starts a write.
                    reg_wr_stb <= 1'b1;
                    reg_wr_nvcfg <= (op_ff == `XFR_OP_WR_NVCFG);
                    reg_wr_data <= wr_sr_ff;
                    timer_start_ff <= 1'b1;
                end
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        state_ff <= ST_CMD;
                        bit_cnt_ff <= 6'h00;
                        wr_any_ff <= 1'b0;
                        dum_cnt_ff <= 5'h00;
                        out_cnt_ff <= 3'h0;
                    end
                    ST_CMD: begin
                        if (in_ev) begin
                            cmd_sr_ff <= cmd_shift;
                            bit_cnt_ff <= bit_nxt;
                            if (bit_nxt == cmd_bits) begin
                                op_ff <= cmd_now;
                                kind_ff <= kind_now;
                                {a_oct_ff, a_ddr_ff, d_oct_ff, d_ddr_ff, a4_ff, dum_ff} <= fmt_now[5:0];
                                // A three-byte address must not inherit upper bits of the previous read.
                                mem_addr <= 32'h0000_0000;
                                bit_cnt_ff <= 6'h00;
                                if (kind_now == `XFR_K_MEM || kind_now == `XFR_K_CFG) begin
                                    state_ff <= ST_ADDR;
                                end else if (kind_now == `XFR_K_REG) begin
                                    state_ff <= ST_DATA;
                                end else if (kind_now == `XFR_K_WRR) begin
                                    state_ff <= ST_WDATA;
                                end else if (kind_now == `XFR_K_NONE) begin
                                    state_ff <= ST_SKIP;
                                end else begin
                                    state_ff <= ST_HOLD;
                                end
                            end
                        end
                    end
                    ST_HOLD: begin
                        // Any further clock voids the enable or disable.
                        if (in_ev) begin
                            state_ff <= ST_SKIP;
                        end
                    end
                    ST_ADDR: begin
                        if (in_ev) begin
                            mem_addr <= addr_shift;
                            bit_cnt_ff <= bit_nxt;
                            if (bit_nxt == addr_bits) begin
                                // Odd DDR start addresses are passed through as given.
                                state_ff <= (dum_ff && dummy_cycles != 5'h00) ? ST_DUMMY : ST_DATA;
                            end
                        end
                    end
                    ST_DUMMY: begin
                        // Dummy cycles counted on rising serial clock edges.
                        if (sclk_rise) begin
                            dum_cnt_ff <= dum_cnt_ff + 5'h01;
                            if (dum_cnt_ff + 5'h01 == dummy_cycles) begin
                                state_ff <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (out_ev) begin
                            lanes_oe <= d_oct_ff ? `XFR_ALL_OE : `XFR_LANE_ONE_OE;
                            if (out_cnt_ff == 3'h0) begin
                                if (kind_ff == `XFR_K_MEM) begin
                                    mem_addr <= mem_addr + 32'h0000_0001;
                                    mem_rd_stb <= 1'b1;
                                end
                                if (d_oct_ff) begin
                                    lanes_out <= out_byte;
                                end else begin
                                    lanes_out[`XFR_LANE_ONE] <= out_byte[7];
                                    out_sr_ff <= {out_byte[6:0], 1'b0};
                                    out_cnt_ff <= 3'h7;
                                end
                            end else begin
                                lanes_out[`XFR_LANE_ONE] <= out_sr_ff[7];
                                out_sr_ff <= {out_sr_ff[6:0], 1'b0};
                                out_cnt_ff <= out_cnt_ff - 3'h1;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (in_ev) begin
                            wr_sr_ff <= wr_shift;
                            bit_cnt_ff <= bit_nxt;
                            if (bit_nxt[2:0] == 3'h0) begin
                                wr_any_ff <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        state_ff <= ST_SKIP;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Write timer
    // ****************************************************************

    // The status and nonvolatile writes run for their own durations.
    xfr_timer #(.WIDTH(32)) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(timer_start_ff),
        .load_cycles(reg_wr_nvcfg ? NV_CYC : SR_CYC),
        .busy(write_in_progress),
        .done(timer_done)
    );

endmodule

// ==== design/xfr_sync.v ====
// Two flip-flop synchroniser for the serial pins.
`timescale 1ns/1ps

module xfr_sync #(
    parameter WIDTH = 10
) (
    // Clock and reset.
    input wire clk_sys,
    input wire rst_n,
    // Asynchronous pins and their synchronised copy.
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    // First stage; only the second stage reads it.
    reg [WIDTH-1:0] meta_ff;
    // Second stage; the only copy logic may look at.
    reg [WIDTH-1:0] sync_ff;

    // ****************************************************************
    // Synchroniser stages
    // ****************************************************************

    // Both stages reset to zero so nothing is undefined at start.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// ==== design/xfr_timer.v ====
// Self-timed countdown for register write completion.
`timescale 1ns/1ps

module xfr_timer #(
    parameter WIDTH = 32
) (
    // Clock and reset.
    input wire clk_sys,
    input wire rst_n,
    // Start pulse and its duration in clock cycles.
    input wire start,
    input wire [WIDTH-1:0] load_cycles,
    // Status.
    output wire busy,
    output reg done
);

    // Remaining cycles; zero means idle.
    reg [WIDTH-1:0] cnt_ff;

    // ****************************************************************
    // Countdown
    // ****************************************************************

    // A start while busy is ignored; the caller never issues one.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_ff <= {WIDTH{1'b0}};
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && cnt_ff == {WIDTH{1'b0}}) begin
                cnt_ff <= load_cycles;
            end else if (cnt_ff != {WIDTH{1'b0}}) begin
                cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
                // Done pulses in the cycle the count reaches zero.
                done <= (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1});
            end
        end
    end

    assign busy = (cnt_ff != {WIDTH{1'b0}});

endmodule

// ==== dv/xfr_core_chk.sv ====
// Assertions on the flash command sequencer ports.
`timescale 1ns/1ps
module xfr_core_chk (
    // Clock, reset and pins.
    input wire clk_sys,
    input wire rst_n,
    input wire sel_n,
    input wire [7:0] lanes_oe,
    // Device state.
    input wire [31:0] mem_addr,
    input wire mem_rd_stb,
    input wire write_enable_latch,
    input wire write_in_progress,
    input wire reg_wr_stb
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_oe_legal: assert property (lanes_oe inside {8'h00, 8'h02, 8'hFF}) else $error("bad enable");
    a_oe_idle: assert property (sel_n [*8] |-> lanes_oe == 8'h00) else $error("lanes held");
    a_wel_commit: assert property ($rose(write_enable_latch) |-> sel_n) else $error("early latch");
    a_write_gate: assert property (reg_wr_stb |-> $past(write_enable_latch)) else $error("no latch");
    a_write_busy: assert property (reg_wr_stb |-> ##[0:2] write_in_progress) else $error("not busy");
    a_stb_pulse: assert property (reg_wr_stb |=> !reg_wr_stb) else $error("long strobe");
    a_done_wel: assert property ($fell(write_in_progress) |-> ##[0:2] !write_enable_latch)
        else $error("latch kept");
    a_addr_step: assert property (mem_rd_stb |-> mem_addr == $past(mem_addr) + 32'h0000_0001)
        else $error("no step");
    a_rd_pulse: assert property (mem_rd_stb |=> !mem_rd_stb) else $error("long read");
    c_wr: cover property (reg_wr_stb);
    c_rd: cover property (mem_rd_stb);
    c_wel: cover property ($rose(write_enable_latch));
endmodule
bind xfr_core xfr_core_chk i_chk (.*);

// ==== dv/xfr_core_tb.sv ====
// Self-checking bench for the flash command sequencer.
`timescale 1ns/1ps
`include "xfr_consts.vh"
module xfr_core_tb;
    // ****
    // Pins and counters
    // ****
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, sel_n, rd_stb, wel, wip, wr_stb, wr_nv, clr_stb;
    logic [7:0] lanes_in, lanes_out, lanes_oe, wr_val;
    logic [7:0] nv = 8'h12, vc = 8'h34, fs = 8'h81;
    logic perr = 1'b0, a4 = 1'b0;
    logic [31:0] mem_addr;
    logic [15:0] wr_data;
    logic [5:0] su = 6'h2D;
    int errors = 0, check_count = 0, wr_seen = 0, clr_seen = 0;
    always #10 clk_sys = ~clk_sys;
    // The commit strobe lasts one cycle, so it is logged here.
    always @(posedge clk_sys) begin
        if (wr_stb === 1'b1) begin
            wr_seen <= wr_seen + 1;
            wr_val <= wr_data[7:0];
        end
        if (clr_stb === 1'b1) begin
            clr_seen <= clr_seen + 1;
        end
    end
    xfr_host i_host (.clk_sys(clk_sys), .lanes_out(lanes_out), .sclk(sclk), .sel_n(sel_n), .lanes_in(lanes_in));
    xfr_core #(.STATUS_WRITE_TIME_NS(20000), .NVCONFIG_WRITE_TIME_NS(24000), .NVCFG_RSVD_MASK(8'hC0)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .sclk(sclk), .sel_n(sel_n), .lanes_in(lanes_in), .lanes_out(lanes_out), .lanes_oe(lanes_oe),
        .octal_ddr_mode(1'b0), .addr4_mode(a4), .dummy_cycles(5'h00), .prot_err(perr), .status_upper(su),
        .flag_status(fs), .nvcfg_value(nv), .vcfg_value(vc), .mem_addr(mem_addr), .mem_rd_stb(rd_stb),
        .mem_rdata(~mem_addr[7:0]), .write_enable_latch(wel), .write_in_progress(wip), .reg_wr_stb(wr_stb),
        .reg_wr_nvcfg(wr_nv), .reg_wr_data(wr_data), .clr_flag_stb(clr_stb));
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    // A wait that runs out ends the run at once.
    task automatic limit(input logic ok);
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: wait ran out", $time);
            complete_run();
        end
    endtask
    task automatic t_wel(input logic [7:0] op, input logic extra, input logic exp);
        logic [7:0] rx;
        i_host.start();
        i_host.xbyte(op, rx);
        if (extra) i_host.xbit(1'b0, rx[0]);
        i_host.stop();
        chk(wel === exp, "write enable latch");
    endtask
    // Reads two bytes after the opcode and address; the memory returns the inverted address.
    task automatic t_rd(input logic [7:0] op, input logic [31:0] a, input int na, input logic [7:0] e0, e1);
        logic [7:0] rx;
        i_host.start();
        i_host.xbyte(op, rx);
        for (int i = na - 1; i >= 0; i--) i_host.xbyte(a[8*i+:8], rx);
        i_host.xbyte(8'h00, rx);
        chk(rx === e0 && lanes_oe === 8'h02, "first byte");
        i_host.xbyte(8'h00, rx);
        chk(rx === e1, "second byte");
        i_host.stop();
        chk(lanes_oe === 8'h00, "lanes kept");
    endtask
    task automatic t_wr(input logic [7:0] op, input logic [7:0] d, input logic extra);
        logic [7:0] rx;
        int n;
        n = wr_seen;
        t_wel(`XFR_OP_WREN, 1'b0, 1'b1);
        i_host.start();
        i_host.xbyte(op, rx);
        i_host.xbyte(d, rx);
        if (extra) i_host.xbit(1'b0, rx[0]);
        i_host.stop();
        if (extra) begin
            chk(wr_seen == n && wel === 1'b1, "voided write");
        end else begin
            chk(wr_seen == n + 1 && wr_val === d && wr_nv === (op == `XFR_OP_WR_NVCFG) && wip === 1'b1,
                "register write");
            t_rd(`XFR_OP_RD_STATUS, 32'h0000_0000, 0, {su, 2'b11}, {su, 2'b11});
            for (int i = 0; i < 1500 && wip !== 1'b0; i++) @(posedge clk_sys);
            limit(wip === 1'b0);
            // The latch drops one cycle after busy ends.
            repeat (2) @(posedge clk_sys);
            chk(wel === 1'b0, "latch after write");
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        limit(1'b0);
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(wel === 1'b0 && wip === 1'b0 && lanes_oe === 8'h00, "reset state");
        t_wel(`XFR_OP_WREN, 1'b0, 1'b1);
        t_wel(`XFR_OP_WRDI, 1'b0, 1'b0);
        t_wel(`XFR_OP_WREN, 1'b1, 1'b0);
        perr <= 1'b1;
        t_wel(`XFR_OP_WREN, 1'b0, 1'b1);
        t_wel(`XFR_OP_WRDI, 1'b0, 1'b1);
        t_wel(`XFR_OP_CLR_FLAG, 1'b0, 1'b0);
        chk(clr_seen == 1, "flag clear strobe");
        perr <= 1'b0;
        t_rd(`XFR_OP_READ, 32'h0000_0010, 3, 8'hEF, 8'hEE);
        t_rd(`XFR_OP_READ4, 32'h0000_01FF, 4, 8'h00, 8'hFF);
        a4 <= 1'b1;
        t_rd(`XFR_OP_READ, 32'h0102_0340, 4, 8'hBF, 8'hBE);
        t_rd(`XFR_OP_RD_VCFG, 32'h0A0B_0C0D, 4, 8'h34, 8'h34);
        chk(mem_addr === 32'h0A0B_0C0D, "config address");
        a4 <= 1'b0;
        t_rd(`XFR_OP_RD_NVCFG, 32'h0000_0000, 3, 8'hD2, 8'hD2);
        t_rd(`XFR_OP_RD_VCFG, 32'h0000_0000, 3, 8'h34, 8'h34);
        t_rd(`XFR_OP_RD_STATUS, 32'h0000_0000, 0, {su, 2'b00}, {su, 2'b00});
        t_rd(`XFR_OP_RD_FLAG, 32'h0000_0000, 0, fs, fs);
        t_wr(`XFR_OP_WR_STATUS, 8'hA5, 1'b1);
        t_wr(`XFR_OP_WR_STATUS, 8'h5A, 1'b0);
        t_wr(`XFR_OP_WR_NVCFG, 8'h3C, 1'b0);
        complete_run();
    end
endmodule

// ==== dv/xfr_host.sv ====
// Host controller model for the serial pins.
`timescale 1ns/1ps
module xfr_host (
    // Clock and device lanes.
    input wire clk_sys,
    input wire [7:0] lanes_out,
    // Pins toward the device.
    output logic sclk = 1'b0,
    output logic sel_n = 1'b1,
    output logic [7:0] lanes_in = 8'h00
);
    // ****
    // Bus cycles
    // ****
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // A bit goes in on the rise; the reply is taken mid high phase.
    task automatic xbit(input logic t, output logic r);
        sclk <= 1'b0;
        lanes_in[0] <= t;
        tick(4);
        sclk <= 1'b1;
        tick(2);
        r = lanes_out[1];
        tick(2);
    endtask
    task automatic xbyte(input logic [7:0] t, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) xbit(t[i], r[i]);
    endtask
    task automatic start();
        sel_n <= 1'b0;
        tick(3);
    endtask
    // Select rises just after the last rise; released lanes invert.
    task automatic stop();
        sel_n <= 1'b1;
        lanes_in <= ~lanes_in;
        tick(4);
        sclk <= 1'b0;
        tick(4);
    endtask
endmodule
